// ### hdl/afs_supervisor.sv
// Purpose: Alarm and fieldbus fault supervisor with LEDs, outputs and history
// Assumes: All inputs synchronous to clk; Wishbone classic single cycles
// Notes:   Blink half period is a parameter so simulation can shorten it
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module afs_supervisor #(
  parameter int BLINK_HALF = afs_pkg::BLINK_HALF_CYC   // Cycles per blink half period
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Fieldbus and settings state
  input  wire logic        link_up,
  input  wire logic        settings_present,
  input  wire logic        settings_corrupt,
  // Monitored quantities
  input  wire logic [7:0]  main_temp_c,
  input  wire logic [7:0]  motor_temp_c,
  input  wire logic [15:0] pulse_speed_rpm,
  // Other alarm sources and clearing events
  input  wire logic        ext_alarm_req,
  input  wire logic [7:0]  ext_alarm_code,
  input  wire logic        preset_done,
  input  wire logic        home_done,
  input  wire logic        alarm_reset_input,
  // Outputs
  output logic             alarm_out_active_high,
  output logic             alarm_out_active_low,
  output logic             motor_stop,
  output logic             network_status_led_green,
  output logic             network_status_led_red,
  output logic             module_status_led_green,
  output logic             module_status_led_red,
  output logic             power_alarm_led_green,
  output logic             power_alarm_led_red,
  output logic             irq
);
  import afs_pkg::*;

  // Codes that only a power-on reset clears
  function automatic logic power_only(input logic [7:0] code);
    power_only = (code == ALM_OVERCUR) || (code == ALM_SENSOR) || (code == ALM_SENSOR_COM);
  endfunction

  // Blink count for each alarm code
  function automatic logic [4:0] blink_count(input logic [7:0] code);
    unique case (code)
      ALM_MAIN_HOT:  blink_count = 5'h02;
      ALM_MOTOR_HOT: blink_count = 5'h08;
      ALM_OVERCUR:   blink_count = 5'h05;
      ALM_SENSOR:    blink_count = 5'h08;
      ALM_SENSOR_COM: blink_count = 5'h08;
      default:       blink_count = 5'h07;
    endcase
  endfunction

  logic [1:0]        rst_sync_q;      // Reset release synchroniser
  logic              rst_n;           // Synchronised reset
  logic              ack_q;           // Bus acknowledge
  logic [31:0]       dat_q;           // Read data
  logic              acc;             // Bus access this cycle
  logic              wr;              // Write taken this cycle
  logic              cmd_rst;         // Alarm reset command
  logic              cmd_clr;         // History clear command
  logic              rst_in_q;        // Previous reset input level
  logic              rst_edge;        // Reset input rising edge
  logic              alarm_q;         // Alarm active
  logic [7:0]        code_q;          // Active alarm code
  logic              raise;           // New alarm this cycle
  logic [7:0]        raise_code;      // Code of the new alarm
  logic              clear;           // Alarm clears this cycle
  logic [7:0]        hist_q [HIST_DEPTH]; // Alarm history, slot 0 newest
  logic [3:0]        hist_cnt_q;      // Valid history entries
  logic [3:0]        hist_sel_q;      // History read index
  logic              corrupt_q;       // Corrupt settings latch
  logic [IRQ_W-1:0]  irq_stat_q;      // Sticky interrupt status
  logic [IRQ_W-1:0]  irq_mask_q;      // Interrupt mask
  logic [IRQ_W-1:0]  irq_set;         // Interrupt events
  logic              link_q;          // Previous link level
  logic              set_err_q;       // Previous settings error level
  logic [31:0]       tick_cnt_q;      // Blink tick divider
  logic              tick;            // One blink half period elapsed
  logic              phase_q;         // Steady blink phase
  logic [4:0]        slot_q;          // Alarm blink slot counter
  logic [4:0]        cnt_now;         // Blinks of active alarm

  // Reset release through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Bus decode
  assign acc     = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr      = acc && wb_we_i && wb_sel_i[0];
  assign cmd_rst = wr && (wb_adr_i == REG_CMD) && wb_dat_i[CMD_ALARM_RESET_INPUT];
  assign cmd_clr = wr && (wb_adr_i == REG_CMD) && wb_dat_i[CMD_HIST_CLR];

  // Acknowledge one cycle after request, read data registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= acc;
      dat_q <= 32'h0000_0000;
      if (acc && !wb_we_i) begin
        unique case (wb_adr_i)
          REG_STATUS:    dat_q <= {12'h000, hist_cnt_q, code_q, 4'h0, alarm_q,
                                   corrupt_q, !settings_present, !link_up};
          REG_HIST_SEL:  dat_q <= {28'h0000000, hist_sel_q};
          REG_HIST_DATA: dat_q <= (hist_sel_q < hist_cnt_q) ?
                                  {24'h000000, hist_q[hist_sel_q]} : 32'h0000_0000;
          REG_IRQ_STAT:  dat_q <= {29'h0000000, irq_stat_q};
          REG_IRQ_MASK:  dat_q <= {29'h0000000, irq_mask_q};
          default:       dat_q <= 32'h0000_0000;      // Unmapped reads zero
        endcase
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Writable configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_sel_q <= HIST_SEL_RST;
      irq_mask_q <= IRQ_MASK_RST;
    end else if (wr) begin
      if (wb_adr_i == REG_HIST_SEL) begin
        hist_sel_q <= wb_dat_i[3:0];
      end
      if (wb_adr_i == REG_IRQ_MASK) begin
        irq_mask_q <= wb_dat_i[IRQ_W-1:0];
      end
    end
  end

  // Reset input edge detector
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_in_q <= 1'b1;                 // A level held through reset is no edge
    end else begin
      rst_in_q <= alarm_reset_input;
    end
  end
  assign rst_edge = alarm_reset_input && !rst_in_q;

  // Threshold compare, fixed priority
  always_comb begin
    raise_code = ALM_NONE;
    if (ext_alarm_req) begin
      raise_code = ext_alarm_code;
    end else if (main_temp_c > TEMP_LIMIT_C) begin
      raise_code = ALM_MAIN_HOT;
    end else if (motor_temp_c > TEMP_LIMIT_C) begin
      raise_code = ALM_MOTOR_HOT;
    end else if (pulse_speed_rpm > PULSE_LIMIT_RPM) begin
      raise_code = ALM_PULSE_ERR;
    end
  end
  assign raise = !alarm_q && (ext_alarm_req || raise_code != ALM_NONE);

  // Clearing paths
  always_comb begin
    clear = 1'b0;
    if (alarm_q && !power_only(code_q)) begin
      clear = rst_edge || cmd_rst;
      if (code_q == ALM_ABS_POS && (preset_done || home_done)) begin
        clear = 1'b1;
      end
    end
  end

  // Active alarm latch, power-on reset clears all
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_q <= 1'b0;
      code_q  <= ALM_NONE;
    end else if (raise) begin
      alarm_q <= 1'b1;
      code_q  <= raise_code;
    end else if (clear) begin
      alarm_q <= 1'b0;
      code_q  <= ALM_NONE;
    end
  end

  // Alarm outputs switch together from one flop
  assign alarm_out_active_high = alarm_q;
  assign alarm_out_active_low  = !alarm_q;
  assign motor_stop            = alarm_q;

  // History shift register, newest in slot 0
  generate
    for (genvar i = 0; i < HIST_DEPTH; i++) begin : g_hist
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          hist_q[i] <= ALM_NONE;
        end else if (cmd_clr) begin
          hist_q[i] <= ALM_NONE;
        end else if (raise) begin
          if (i == 0) begin
            hist_q[i] <= raise_code;
          end else begin
            hist_q[i] <= hist_q[(i > 0) ? i - 1 : 0];
          end
        end
      end
    end
  endgenerate

  // History fill count saturates at depth
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_cnt_q <= 4'h0;
    end else if (cmd_clr) begin
      hist_cnt_q <= 4'h0;
    end else if (raise && hist_cnt_q != HIST_DEPTH_C) begin
      hist_cnt_q <= hist_cnt_q + 4'h1;
    end
  end

  // Corrupt settings stay until power-on reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      corrupt_q <= 1'b0;
    end else if (settings_corrupt) begin
      corrupt_q <= 1'b1;
    end
  end

  // Sticky interrupt status, set wins over clear
  assign irq_set = {(corrupt_q || !settings_present) && !set_err_q, !link_up && link_q, raise};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= 3'h0;
      link_q     <= 1'b1;
      set_err_q  <= 1'b0;
    end else begin
      link_q    <= link_up;
      set_err_q <= corrupt_q || !settings_present;
      if (wr && wb_adr_i == REG_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~wb_dat_i[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat_q <= irq_stat_q | irq_set;
      end
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // Blink tick divider and steady blink phase
  assign tick = (tick_cnt_q == 32'(BLINK_HALF - 1));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 32'h0000_0000;
      phase_q    <= 1'b0;
    end else if (tick) begin
      tick_cnt_q <= 32'h0000_0000;
      phase_q    <= !phase_q;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  // Alarm blink slots: count lit pulses, then a dark gap
  assign cnt_now = blink_count(code_q);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_q <= 5'h00;
    end else if (!alarm_q) begin
      slot_q <= 5'h00;
    end else if (tick) begin
      if (slot_q >= 5'((cnt_now << 1) + BLINK_GAP_SLOTS - 5'h01)) begin
        slot_q <= 5'h00;
      end else begin
        slot_q <= slot_q + 5'h01;
      end
    end
  end

  // LED drivers
  assign network_status_led_green = link_up;
  assign network_status_led_red   = !link_up && phase_q;
  assign module_status_led_red    = corrupt_q && phase_q;
  assign module_status_led_green  = !corrupt_q &&
                                    (settings_present || phase_q);
  assign power_alarm_led_green    = !alarm_q;
  assign power_alarm_led_red      = alarm_q && !slot_q[0] &&
                                    (slot_q < 5'(cnt_now << 1));

  // Checks
  chk_alarm_outs: assert property (@(posedge clk) disable iff (!rst_n)
    alarm_out_active_high == !alarm_out_active_low && motor_stop == alarm_out_active_high)
    else $error("alarm outputs disagree");
  chk_raise_next: assert property (@(posedge clk) disable iff (!rst_n)
    raise |=> alarm_q && code_q == $past(raise_code))
    else $error("alarm not raised");
  chk_main_hot: assert property (@(posedge clk) disable iff (!rst_n)
    !alarm_q && !ext_alarm_req && main_temp_c > TEMP_LIMIT_C |=> code_q == ALM_MAIN_HOT)
    else $error("main overheat missed");
  chk_motor_hot: assert property (@(posedge clk) disable iff (!rst_n)
    !alarm_q && !ext_alarm_req && main_temp_c <= TEMP_LIMIT_C
    && motor_temp_c > TEMP_LIMIT_C |=> code_q == ALM_MOTOR_HOT)
    else $error("motor overheat missed");
  chk_pulse_err: assert property (@(posedge clk) disable iff (!rst_n)
    raise && raise_code == ALM_PULSE_ERR |-> pulse_speed_rpm > PULSE_LIMIT_RPM)
    else $error("pulse alarm without cause");
  chk_edge_clear: assert property (@(posedge clk) disable iff (!rst_n)
    alarm_q && !power_only(code_q) && rst_edge |=> !alarm_q)
    else $error("reset edge ignored");
  chk_level_hold: assert property (@(posedge clk) disable iff (!rst_n)
    alarm_reset_input && $past(alarm_reset_input) |-> !rst_edge)
    else $error("held level resets");
  chk_cmd_clear: assert property (@(posedge clk) disable iff (!rst_n)
    alarm_q && !power_only(code_q) && cmd_rst |=> !alarm_q)
    else $error("command reset ignored");
  chk_power_only: assert property (@(posedge clk) disable iff (!rst_n)
    alarm_q && power_only(code_q) |=> alarm_q && $stable(code_q))
    else $error("power-only alarm cleared");
  chk_abs_clear: assert property (@(posedge clk) disable iff (!rst_n)
    alarm_q && code_q == ALM_ABS_POS && (preset_done || home_done) |=> !alarm_q)
    else $error("absolute alarm kept");
  chk_hist_push: assert property (@(posedge clk) disable iff (!rst_n)
    raise && !cmd_clr |=> hist_q[0] == $past(raise_code) && hist_q[1] == $past(hist_q[0]))
    else $error("history not shifted");
  chk_hist_full: assert property (@(posedge clk) disable iff (!rst_n)
    hist_cnt_q == HIST_DEPTH_C && raise && !cmd_clr |=> hist_cnt_q == HIST_DEPTH_C
    && hist_q[9] == $past(hist_q[8]))
    else $error("full history wrong");
  chk_hist_clr: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_clr |=> hist_cnt_q == 4'h0 && hist_q[0] == ALM_NONE)
    else $error("history not erased");
  chk_net_led: assert property (@(posedge clk) disable iff (!rst_n)
    link_up |-> network_status_led_green && !network_status_led_red)
    else $error("network LED wrong");
  chk_module_status_led: assert property (@(posedge clk) disable iff (!rst_n)
    corrupt_q |-> !module_status_led_green)
    else $error("module LED green on corrupt");
endmodule

// ### hdl/afs_pkg.sv
// Purpose: Constants, register map and alarm codes of the fault supervisor
// Assumes: 50 MHz clock, 32-bit classic Wishbone register bus
// Notes:   Offsets are byte addresses, one aligned word each
package afs_pkg;
  // Clock and blink timing
  localparam int          CLK_HZ          = 50_000_000;
  localparam int          BLINK_HALF_MS   = 200;             // Half period of one blink
  localparam int          BLINK_HALF_CYC  = (CLK_HZ / 1000) * BLINK_HALF_MS;
  localparam logic [4:0]  BLINK_GAP_SLOTS = 5'h04;           // Extra dark slots after each group

  // Register offsets
  localparam logic [7:0]  REG_STATUS      = 8'h00;
  localparam logic [7:0]  REG_CMD         = 8'h04;
  localparam logic [7:0]  REG_HIST_SEL    = 8'h08;
  localparam logic [7:0]  REG_HIST_DATA   = 8'h0C;
  localparam logic [7:0]  REG_IRQ_STAT    = 8'h10;
  localparam logic [7:0]  REG_IRQ_MASK    = 8'h14;

  // Command bits
  localparam int          CMD_ALARM_RESET_INPUT     = 0;
  localparam int          CMD_HIST_CLR    = 1;

  // Interrupt bits
  localparam int          IRQ_ALARM       = 0;
  localparam int          IRQ_COMM_TO     = 1;
  localparam int          IRQ_SET_ERR     = 2;
  localparam int          IRQ_W           = 3;

  // Alarm history
  localparam int          HIST_DEPTH      = 10;
  localparam logic [3:0]  HIST_DEPTH_C    = 4'hA;

  // Alarm codes
  localparam logic [7:0]  ALM_NONE        = 8'h00;
  localparam logic [7:0]  ALM_MAIN_HOT    = 8'h21;
  localparam logic [7:0]  ALM_MOTOR_HOT   = 8'h26;
  localparam logic [7:0]  ALM_PULSE_ERR   = 8'h34;
  localparam logic [7:0]  ALM_ABS_POS     = 8'h65;           // Absolute position error
  localparam logic [7:0]  ALM_OVERCUR     = 8'h20;
  localparam logic [7:0]  ALM_SENSOR      = 8'h28;
  localparam logic [7:0]  ALM_SENSOR_COM  = 8'h2A;

  // Generation thresholds
  localparam logic [7:0]  TEMP_LIMIT_C    = 8'h55;           // 85 degrees Celsius
  localparam logic [15:0] PULSE_LIMIT_RPM = 16'h9600;        // 38,400 r/min

  // Reset values
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic [3:0]  HIST_SEL_RST    = 4'h0;
endpackage

// ### dv/afs_host_model.sv
// Purpose: Host controller and discrete I/O model at the supervisor's far side
// Assumes: Bench calls its tasks from the main sequence
// Notes:   Bench removes the alarm cause before raising the reset line
`timescale 1ns/1ps
module afs_host_model (
  // Clock
  input  wire logic clk,
  // Connection and settings state
  output logic      link_up,
  output logic      settings_present,
  output logic      settings_corrupt,
  // Discrete reset line
  output logic      alarm_reset_input
);
  // Connected, configured, reset line off
  initial begin
    link_up           = 1'b1;
    settings_present  = 1'b1;
    settings_corrupt  = 1'b0;
    alarm_reset_input = 1'b0;
  end
  // New connection and settings state just after an edge
  task automatic set_state(input logic lk, input logic pr, input logic co);
    @(posedge clk);
    link_up          <= lk;
    settings_present <= pr;
    settings_corrupt <= co;
  endtask
  // Reset line level, changed just after an edge
  task automatic drive_reset(input logic lv);
    @(posedge clk);
    alarm_reset_input <= lv;
  endtask
endmodule

// ### dv/afs_supervisor_tb.sv
// Purpose: Self-checking bench of the fault supervisor
// Assumes: Blink half period shortened to 4 cycles
// Notes:   Random alarm codes come from an LFSR
`timescale 1ns/1ps
module afs_supervisor_tb;
  import afs_pkg::*;
  localparam int BH = 4;                   // Blink half period
  logic        clk = 1'b0, resetn = 1'b0;  // Clock and reset
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0; // Bus request
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [3:0]  bs = 4'hF;                  // Byte selects of the next request
  logic [31:0] wd = 32'h0, rd, rq;         // Write, read, taken data
  logic        ack, ah, al, stp, nsg, nsr, msg, msr, pag, par, irq;
  logic [7:0]  mt = 8'h00, mo = 8'h00, ec = 8'h00; // Sources
  logic [15:0] rpm = 16'h0000;
  logic        er = 1'b0, pre = 1'b0, hom = 1'b0;
  logic        lk, pr, co, ar;              // From host model
  logic [15:0] lf = 16'h846A;               // LFSR seed 33898
  logic [7:0]  q [12];                      // Codes raised, oldest first
  logic [7:0]  cd [3] = '{ALM_MAIN_HOT, ALM_MOTOR_HOT, ALM_PULSE_ERR};
  int          bad_count = 0, compares = 0, cycles = 0, n;
  int          r_nr = 0, r_mg = 0, r_mr = 0; // LED rising edges

  // Free-running clock
  always #10 clk = ~clk;
  // Rising edges of blinking LEDs
  always @(posedge nsr) r_nr++;
  always @(posedge msg) r_mg++;
  always @(posedge msr) r_mr++;

  afs_host_model HM (.clk(clk), .link_up(lk), .settings_present(pr),
    .settings_corrupt(co), .alarm_reset_input(ar));
  afs_supervisor #(.BLINK_HALF(BH)) DUT (.clk(clk), .resetn(resetn),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .link_up(lk), .settings_present(pr),
    .settings_corrupt(co), .main_temp_c(mt), .motor_temp_c(mo), .pulse_speed_rpm(rpm),
    .ext_alarm_req(er), .ext_alarm_code(ec), .preset_done(pre), .home_done(hom),
    .alarm_reset_input(ar), .alarm_out_active_high(ah), .alarm_out_active_low(al),
    .motor_stop(stp), .network_status_led_green(nsg), .network_status_led_red(nsr),
    .module_status_led_green(msg), .module_status_led_red(msr),
    .power_alarm_led_green(pag), .power_alarm_led_red(par), .irq(irq));

  // Counts and verdict, then stop
  task automatic test_done;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end
  // One comparison
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic single Wishbone cycle; data taken at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wd, sel} <= {1'b1, 1'b1, w, a, d, bs};
    do @(posedge clk); while (ack !== 1'b1);
    rq = rd;
    {cyc, stb, we} <= 3'b000;
    @(posedge clk);
  endtask
  // Settle past an edge's updates
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // LFSR step
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Blinks per group for a code
  function automatic int exp_blinks(input logic [7:0] c);
    case (c)
      ALM_MAIN_HOT: return 2;
      ALM_MOTOR_HOT, ALM_SENSOR, ALM_SENSOR_COM: return 8;
      ALM_OVERCUR: return 5;
      default: return 7;
    endcase
  endfunction
  // Other alarm source
  task automatic ext(input logic r, input logic [7:0] c);
    @(posedge clk);
    er <= r;
    ec <= c;
  endtask
  // Monitored quantities
  task automatic src(input logic [7:0] a, input logic [7:0] b, input logic [15:0] c);
    @(posedge clk);
    {mt, mo, rpm} <= {a, b, c};
  endtask
  // Alarm state at outputs and status
  task automatic chk_alm(input logic on, input logic [7:0] c);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("alarm_hi", {31'h0, on}, {31'h0, ah});
    chk("alarm_lo", {31'h0, !on}, {31'h0, al});
    chk("motor_stop", {31'h0, on}, {31'h0, stp});
    chk("alarm_led_green", {31'h0, !on}, {31'h0, pag});
    chk("active", {31'h0, on}, {31'h0, rq[3]});
    if (on) chk("code", {24'h0, c}, {24'h0, rq[15:8]});
  endtask
  // Count LED edges over a window
  task automatic win;
    tick(2);
    {r_nr, r_mg, r_mr} = '0;
    tick(12 * BH);
  endtask
  // Rising edges of one blink group of the alarm LED
  task automatic blink_group(output int k);
    int lo;
    logic pv;
    lo = 0;
    k = 0;
    pv = 1'b0;
    while (lo < 3 * BH) begin
      @(posedge clk);
      lo = par ? 0 : lo + 1;
    end
    while (k == 0 || lo < 3 * BH) begin
      @(posedge clk);
      if (par && !pv) k++;
      pv = par;
      lo = par ? 0 : lo + 1;
    end
  endtask

  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset values and an unmapped word
    wb(1'b0, REG_IRQ_MASK, 32'h0); chk("mask", 32'h0, rq);
    // A write without the low byte select is ignored
    bs = 4'hE;
    wb(1'b1, REG_IRQ_MASK, 32'h7);
    bs = 4'hF;
    wb(1'b0, REG_IRQ_MASK, 32'h0);
    chk("mask_no_sel", 32'h0, rq);
    wb(1'b0, REG_HIST_SEL, 32'h0); chk("sel", 32'h0, rq);
    wb(1'b0, 8'h18, 32'h0); chk("unmapped", 32'h0, rq);
    chk_alm(1'b0, 8'h00);
    // Link lost, then back
    HM.set_state(1'b0, 1'b1, 1'b0); win;
    chk("ns_red_blink", 32'h1, {31'h0, r_nr > 0});
    HM.set_state(1'b1, 1'b1, 1'b0); win;
    chk("network_status_led", 32'h2, {30'h0, nsg, nsr | (r_nr > 0)});
    // Settings missing, then present
    HM.set_state(1'b1, 1'b0, 1'b0); win;
    chk("ms_green_blink", 32'h1, {31'h0, r_mg > 0});
    HM.set_state(1'b1, 1'b1, 1'b0); win;
    chk("module_status_led", 32'h2, {30'h0, msg, msr | (r_mg > 0)});
    // Thresholds: limit keeps quiet, one above raises at once
    wb(1'b1, REG_IRQ_STAT, 32'h7);
    wb(1'b1, REG_IRQ_MASK, 32'h1);
    for (int k = 0; k < 3; k++) begin
      for (int o = 0; o < 2; o++) begin
        src(k == 0 ? 8'(TEMP_LIMIT_C + o) : 8'h00, k == 1 ? 8'(TEMP_LIMIT_C + o) : 8'h00,
            k == 2 ? 16'(PULSE_LIMIT_RPM + o) : 16'h0000);
        tick(1);
        chk("raised_now", o, {31'h0, ah});
      end
      chk_alm(1'b1, cd[k]);
      blink_group(n);
      chk("blinks", exp_blinks(cd[k]), n);
      if (k == 0) begin
        chk("irq_on", 32'h1, {31'h0, irq});
        wb(1'b1, REG_IRQ_MASK, 32'h0); chk("irq_masked", 32'h0, {31'h0, irq});
        wb(1'b1, REG_IRQ_MASK, 32'h1); chk("irq_back", 32'h1, {31'h0, irq});
        wb(1'b1, REG_IRQ_STAT, 32'h1); chk("irq_clear", 32'h0, {31'h0, irq});
      end
      src(8'h00, 8'h00, 16'h0000);
      wb(1'b1, REG_CMD, 32'h1); tick(1);
      chk_alm(1'b0, 8'h00);
    end
    // Reset line: one edge clears, a held level does not
    ext(1'b1, 8'h40); tick(1); ext(1'b0, 8'h00);
    HM.drive_reset(1'b1); tick(4);
    chk_alm(1'b0, 8'h00);
    ext(1'b1, 8'h41); tick(1); ext(1'b0, 8'h00); tick(4);
    chk_alm(1'b1, 8'h41);
    HM.drive_reset(1'b0); HM.drive_reset(1'b1); tick(4);
    chk_alm(1'b0, 8'h00);
    HM.drive_reset(1'b0);
    // Power-only code ignores both reset paths
    ext(1'b1, ALM_OVERCUR); tick(1); ext(1'b0, 8'h00);
    wb(1'b1, REG_CMD, 32'h1); HM.drive_reset(1'b1); HM.drive_reset(1'b0); tick(4);
    chk_alm(1'b1, ALM_OVERCUR);
    blink_group(n);
    chk("blinks_oc", exp_blinks(ALM_OVERCUR), n);
    // Corrupt settings blink red until power-on
    HM.set_state(1'b1, 1'b1, 1'b1); win;
    chk("ms_red_blink", 32'h1, {31'h0, (r_mr > 0) & !msg});
    HM.set_state(1'b1, 1'b1, 1'b0);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    chk_alm(1'b0, 8'h00);
    win;
    chk("ms_after_rst", 32'h2, {30'h0, msg, msr | (r_mr > 0)});
    // Position alarm cleared by preset, then by homing
    for (int h = 0; h < 2; h++) begin
      ext(1'b1, ALM_ABS_POS); tick(1); ext(1'b0, 8'h00);
      @(posedge clk); {pre, hom} <= h ? 2'b01 : 2'b10;
      @(posedge clk); {pre, hom} <= 2'b00;
      tick(2);
      chk_alm(1'b0, 8'h00);
    end
    // Twelve random codes overflow the history
    for (int i = 0; i < 12; i++) begin
      lf = nxt(lf);
      q[i] = {3'b010, lf[4:0]};
      ext(1'b1, q[i]); tick(1); ext(1'b0, 8'h00);
      wb(1'b1, REG_CMD, 32'h1);
    end
    wb(1'b0, REG_STATUS, 32'h0);
    chk("hist_count", {28'h0, HIST_DEPTH_C}, {28'h0, rq[19:16]});
    for (int k = 0; k < 11; k++) begin
      wb(1'b1, REG_HIST_SEL, 32'(k));
      wb(1'b0, REG_HIST_DATA, 32'h0);
      chk("hist_entry", k < 10 ? {24'h0, q[11 - k]} : 32'h0, rq);
    end
    wb(1'b1, REG_CMD, 32'h2);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("hist_cleared", 32'h0, {28'h0, rq[19:16]});
    test_done();
  end
endmodule
